//--- rtl/siw_pkg.sv
// Constants shared by the supervisor interrupt and wake-up logic
`default_nettype none
package siw_pkg;
    // Clock and serial framing
    localparam int          CLK_HZ            = 25_000_000;
    localparam int          SPI_BITS          = 16;
    localparam logic [4:0]  SPI_BITS_W        = 5'h10;
    localparam logic [4:0]  SPI_ADDR_DONE     = 5'h05;
    localparam logic [4:0]  SPI_PARITY_IDX    = 5'h06;
    localparam logic [4:0]  SPI_FIRST_DATA    = 5'h08;
    localparam int          RX_ADDR_HI        = 15;
    localparam int          RX_ADDR_LO        = 11;
    localparam int          RX_RW             = 10;
    localparam int          RX_PARITY         = 9;
    // Register map
    localparam logic [4:0]  ADDR_ENABLES      = 5'h04;
    localparam logic [4:0]  ADDR_FLAGS        = 5'h05;
    localparam logic [7:0]  REG_RESET         = 8'h00;
    localparam logic [7:0]  REG_USED_MASK     = 8'h3e;
    localparam logic [7:0]  FLAG_CLEARABLE    = 8'h3c;
    localparam logic [7:0]  READ_UNMAPPED     = 8'h00;
    // Shared bit positions in flags and enables
    localparam int          BIT_LINE_EDGE     = 5;
    localparam int          BIT_OVERTEMP      = 4;
    localparam int          BIT_SUPPLY_LOW    = 3;
    localparam int          BIT_SUPPLY_HIGH   = 2;
    localparam int          BIT_OVERCURRENT   = 1;
    // Chopping input: slowest recommended rate sets the period window
    localparam int          CHOP_MIN_FREQ_HZ  = 100;
    localparam int          CHOP_MAX_FREQ_HZ  = 20_000;
    localparam int          CHOP_CNT_W        = 18;
    localparam int          OC_SOURCES        = 5;
    localparam int          RST_SOURCES       = 4;
endpackage : siw_pkg
`default_nettype wire

//--- rtl/siw_spi_slave.sv
// Serial register port: 16-bit frame, address byte then data byte
`default_nettype none
module siw_spi_slave
    import siw_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic       i_nrst,
    input  wire logic       i_ss_n,
    input  wire logic       i_sck,
    input  wire logic       i_mosi,
    input  wire logic [7:0] i_status,
    input  wire logic [7:0] i_rd_data,
    output logic [4:0]      o_addr,
    output logic            o_wr_strobe,
    output logic [7:0]      o_wr_data,
    output logic            o_miso,
    output logic            o_miso_oe_n
);
    logic [2:0]  sync1;
    logic [2:0]  sync2;
    logic        ss_q;
    logic        sck_q;
    logic [15:0] rx;
    logic [4:0]  falls;
    logic [4:0]  rises;
    logic        rw;
    logic [7:0]  status_hold;
    logic [7:0]  data_hold;
    logic [15:0] next_rx;
    logic [4:0]  next_falls;
    logic [4:0]  next_rises;
    logic [4:0]  next_addr;
    logic        next_rw;
    logic [7:0]  next_status_hold;
    logic [7:0]  next_data_hold;
    logic        next_miso;
    logic        next_miso_oe_n;
    logic        next_wr_strobe;
    logic [7:0]  next_wr_data;
    logic        ss_s;
    logic        sck_s;
    logic        mosi_s;

    assign ss_s   = sync2[2];
    assign sck_s  = sync2[1];
    assign mosi_s = sync2[0];

    always_comb begin
        next_rx          = rx;
        next_falls       = falls;
        next_rises       = rises;
        next_addr        = o_addr;
        next_rw          = rw;
        next_status_hold = status_hold;
        next_data_hold   = data_hold;
        next_miso        = o_miso;
        next_miso_oe_n   = ss_s;
        next_wr_strobe   = 1'b0;
        next_wr_data     = o_wr_data;
        if (ss_q && !ss_s) begin
            next_falls       = '0;
            next_rises       = '0;
            next_status_hold = i_status;
        end else if (!ss_s) begin
            // Data out moves on the rising serial clock
            if (!sck_q && sck_s) begin
                if (rises < SPI_FIRST_DATA)
                    next_miso = status_hold[3'(7 - rises)];
                else if (rises < SPI_BITS_W)
                    next_miso = data_hold[3'(15 - rises)];
                if (rises <= SPI_BITS_W)
                    next_rises = rises + 5'h01;
            end
            // Data in is sampled on the falling serial clock
            if (sck_q && !sck_s) begin
                next_rx = {rx[14:0], mosi_s};
                if (falls <= SPI_BITS_W)
                    next_falls = falls + 5'h01;
                if (falls == SPI_ADDR_DONE) begin
                    next_addr = next_rx[5:1];
                    next_rw   = next_rx[0];
                end
                // Read data is caught as the parity bit goes by
                if (falls == SPI_PARITY_IDX)
                    next_data_hold = i_rd_data;
            end
        end else if (!ss_q && ss_s) begin
            // Write lands on the closing edge, only for exact, odd-free frames
            if (falls == SPI_BITS_W && !rw &&
                (rx[RX_PARITY] == ^rx[RX_ADDR_HI:RX_RW])) begin
                next_addr      = rx[RX_ADDR_HI:RX_ADDR_LO];
                next_wr_strobe = 1'b1;
                next_wr_data   = rx[7:0];
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            // Idle pin levels, select high and clock low, so no false edge
            sync1       <= 3'h4;
            sync2       <= 3'h4;
            ss_q        <= 1'b1;
            sck_q       <= 1'b0;
            rx          <= '0;
            falls       <= '0;
            rises       <= '0;
            o_addr      <= '0;
            rw          <= 1'b1;
            status_hold <= '0;
            data_hold   <= '0;
            o_miso      <= 1'b0;
            o_miso_oe_n <= 1'b1;
            o_wr_strobe <= 1'b0;
            o_wr_data   <= '0;
        end else begin
            sync1       <= {i_ss_n, i_sck, i_mosi};
            sync2       <= sync1;
            ss_q        <= ss_s;
            sck_q       <= sck_s;
            rx          <= next_rx;
            falls       <= next_falls;
            rises       <= next_rises;
            o_addr      <= next_addr;
            rw          <= next_rw;
            status_hold <= next_status_hold;
            data_hold   <= next_data_hold;
            o_miso      <= next_miso;
            o_miso_oe_n <= next_miso_oe_n;
            o_wr_strobe <= next_wr_strobe;
            o_wr_data   <= next_wr_data;
        end
    end

    // no write from a short frame
    AST_WR_NEEDS_FRAME: assert property (@(posedge i_clock) disable iff (!i_nrst)
        $rose(o_wr_strobe) |-> $past(falls) == SPI_BITS_W && $past(ss_s))
        else $error("write strobe without a full frame");
endmodule : siw_spi_slave
`default_nettype wire

//--- rtl/siw_supervisor.sv
// Flag, enable, interrupt and wake-up logic of the supervisor die
`default_nettype none
// Notes on behaviour
// - After reset all interrupt sources are disabled.
// - Host sets or clears each source enable by serial register write.
// - Supply below low threshold sets its flag; enabled flag interrupts.
// - Low supply turns off half-bridge high sides only.
// - Low supply detection is off during stop mode.
// - Supply above high threshold sets its flag; enabled flag interrupts.
// - High supply turns off half-bridge high sides only.
// - High supply detection is off during stop mode.
// - Over-temperature sets its flag; enabled flag interrupts.
// - Over-temperature detection is off during stop mode.
// - Falling bus line edge interrupts when its enable is set.
// - In stop mode a falling bus line edge starts system wake-up when its enable is set.
// - Overcurrent on any bridge or switched supply interrupts when enabled.
// - Wake events: line edge, watchdog wake, supply low reset.
// - Qualified wake event wakes host and main regulator.
// - Flags in bits 5..1; bits 7, 6, 0 read zero; reset zero.
// - Interrupt is active-low open-drain output.
// - System reset line pulled low while any internal source asserts.
// - Chopping input gives only the period; duty made inside.
// - Flags except overcurrent clear by writing one; zero does nothing.
// - Over-temperature clear ignored while the condition persists.
// - Enable register holds per-source enables in bits 5..1, reset zero.
module siw_supervisor
    import siw_pkg::*;
#(
    parameter int CHOP_MAX_CYCLES = CLK_HZ / CHOP_MIN_FREQ_HZ
)(
    input  wire logic                   i_clock,
    input  wire logic                   i_nrst,
    input  wire logic                   i_ss_n,
    input  wire logic                   i_sck,
    input  wire logic                   i_mosi,
    output logic                        o_miso,
    output logic                        o_miso_oe_n,
    input  wire logic                   i_supply_low,
    input  wire logic                   i_supply_high,
    input  wire logic                   i_overtemp,
    input  wire logic                   i_line_rx,
    input  wire logic [OC_SOURCES-1:0]  i_overcurrent,
    input  wire logic                   i_overcurrent_clr,
    input  wire logic                   i_stop_mode,
    input  wire logic                   i_watchdog_wake,
    input  wire logic                   i_supply_low_reset,
    input  wire logic [RST_SOURCES-1:0] i_reset_sources,
    input  wire logic                   i_chop_freq_in,
    output logic                        o_irq_out,
    output logic                        o_irq_oe_n,
    output logic                        o_sys_rst_out,
    output logic                        o_sys_rst_oe_n,
    output logic                        o_high_side_off,
    output logic                        o_wake_host,
    output logic                        o_wake_regulator,
    output logic                        o_chop_pwm
);
    localparam int SYNC_W = 8 + OC_SOURCES + RST_SOURCES;
    // Line idles high; resetting its stage low would fake a falling edge
    localparam logic [SYNC_W-1:0] SYNC_IDLE = {3'h0, 1'b1, 4'h0, {OC_SOURCES{1'b0}}, {RST_SOURCES{1'b0}}};

    logic [SYNC_W-1:0]      sync1;
    logic [SYNC_W-1:0]      sync2;
    logic                   low_s;
    logic                   high_s;
    logic                   hot_s;
    logic                   line_s;
    logic                   stop_s;
    logic                   wdog_s;
    logic                   lvr_s;
    logic                   chop_s;
    logic [OC_SOURCES-1:0]  oc_s;
    logic [RST_SOURCES-1:0] rst_s;
    logic                   line_q;
    logic                   chop_q;
    logic [7:0]             event_flags;
    logic [7:0]             event_enables;
    logic [7:0]             next_flags;
    logic [7:0]             next_enables;
    logic [7:0]             set_mask;
    logic [7:0]             clr_mask;
    logic                   line_fall;
    logic                   next_irq_oe_n;
    logic                   next_rst_oe_n;
    logic                   next_high_side_off;
    logic                   wake;
    logic                   next_wake;
    logic [4:0]             reg_addr;
    logic                   wr_strobe;
    logic [7:0]             wr_data;
    logic [7:0]             rd_data;
    logic [CHOP_CNT_W-1:0]  chop_cnt;
    logic [CHOP_CNT_W-1:0]  chop_period;
    logic [CHOP_CNT_W-1:0]  next_chop_cnt;
    logic [CHOP_CNT_W-1:0]  next_chop_period;
    logic                   next_chop_pwm;

    assign {low_s, high_s, hot_s, line_s, stop_s, wdog_s, lvr_s, chop_s, oc_s, rst_s} = sync2;
    assign line_fall = line_q && !line_s;

    siw_spi_slave u_spi (
        .i_clock     (i_clock),
        .i_nrst      (i_nrst),
        .i_ss_n      (i_ss_n),
        .i_sck       (i_sck),
        .i_mosi      (i_mosi),
        .i_status    (event_flags),
        .i_rd_data   (rd_data),
        .o_addr      (reg_addr),
        .o_wr_strobe (wr_strobe),
        .o_wr_data   (wr_data),
        .o_miso      (o_miso),
        .o_miso_oe_n (o_miso_oe_n)
    );

    // Pins from analog comparators and the host cross into this clock here
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            sync1  <= SYNC_IDLE;
            sync2  <= SYNC_IDLE;
            line_q <= 1'b1;
            chop_q <= 1'b0;
        end else begin
            sync1  <= {i_supply_low, i_supply_high, i_overtemp, i_line_rx, i_stop_mode,
                       i_watchdog_wake, i_supply_low_reset, i_chop_freq_in, i_overcurrent, i_reset_sources};
            sync2  <= sync1;
            line_q <= line_s;
            chop_q <= chop_s;
        end
    end

    always_comb begin
        case (reg_addr)
            ADDR_ENABLES: rd_data = event_enables;
            ADDR_FLAGS:   rd_data = event_flags;
            default:      rd_data = READ_UNMAPPED;
        endcase
    end

    always_comb begin
        set_mask = '0;
        set_mask[BIT_SUPPLY_LOW]  = low_s && !stop_s;
        set_mask[BIT_SUPPLY_HIGH] = high_s && !stop_s;
        set_mask[BIT_OVERTEMP]    = hot_s && !stop_s;
        set_mask[BIT_LINE_EDGE]   = line_fall;
        // any bridge or switched supply overcurrent
        set_mask[BIT_OVERCURRENT] = |oc_s;
        clr_mask = '0;
        if (wr_strobe && reg_addr == ADDR_FLAGS)
            clr_mask = wr_data & FLAG_CLEARABLE;
        clr_mask[BIT_OVERCURRENT] = i_overcurrent_clr;
        if (hot_s)
            clr_mask[BIT_OVERTEMP] = 1'b0;
        if (low_s)
            clr_mask[BIT_SUPPLY_LOW] = 1'b0;
        if (high_s)
            clr_mask[BIT_SUPPLY_HIGH] = 1'b0;
        // Set beats clear so no event slips through a clear
        next_flags = ((event_flags & ~clr_mask) | set_mask) & REG_USED_MASK;
        next_enables = event_enables;
        if (wr_strobe && reg_addr == ADDR_ENABLES)
            next_enables = wr_data & REG_USED_MASK;
        // drive low through the enable, else let the pull-up win
        next_irq_oe_n = !(|(next_flags & next_enables));
        // any internal reset source pulls the line
        next_rst_oe_n = !(|rst_s);
        next_high_side_off = (low_s || high_s) && !stop_s;
        next_wake = wake;
        if (!stop_s)
            next_wake = 1'b0;
        else if ((line_fall && event_enables[BIT_LINE_EDGE]) || wdog_s || lvr_s)
            next_wake = 1'b1;
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            event_flags     <= REG_RESET;
            event_enables   <= REG_RESET;
            o_irq_oe_n      <= 1'b1;
            o_sys_rst_oe_n  <= 1'b1;
            o_high_side_off <= 1'b0;
            wake            <= 1'b0;
        end else begin
            event_flags     <= next_flags;
            event_enables   <= next_enables;
            o_irq_oe_n      <= next_irq_oe_n;
            o_sys_rst_oe_n  <= next_rst_oe_n;
            o_high_side_off <= next_high_side_off;
            wake            <= next_wake;
        end
    end

    assign o_irq_out        = 1'b0;
    assign o_sys_rst_out    = 1'b0;
    assign o_wake_host      = wake;
    assign o_wake_regulator = wake;

    always_comb begin
        next_chop_cnt    = chop_cnt;
        next_chop_period = chop_period;
        // measure the period, duty is half of it
        if (!chop_q && chop_s) begin
            // Count starts at zero, so the period is one more than the count
            next_chop_period = chop_cnt + 1'b1;
            next_chop_cnt    = '0;
        end else if (chop_cnt < CHOP_CNT_W'(CHOP_MAX_CYCLES)) begin
            next_chop_cnt = chop_cnt + 1'b1;
        end else begin
            // Input stalled below the slowest rate: stop chopping
            next_chop_period = '0;
        end
        next_chop_pwm = next_chop_cnt < (next_chop_period >> 1);
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            chop_cnt    <= '0;
            chop_period <= '0;
            o_chop_pwm  <= 1'b0;
        end else begin
            chop_cnt    <= next_chop_cnt;
            chop_period <= next_chop_period;
            o_chop_pwm  <= next_chop_pwm;
        end
    end

    AST_EN_AFTER_RESET: assert property (@(posedge i_clock)
        $rose(i_nrst) |-> event_enables == REG_RESET)
        else $error("enables not cleared by reset");
    AST_EN_WRITE: assert property (@(posedge i_clock) disable iff (!i_nrst)
        wr_strobe && reg_addr == ADDR_ENABLES |=> event_enables == ($past(wr_data) & REG_USED_MASK))
        else $error("enable write not taken");
    AST_LOW_SETS: assert property (@(posedge i_clock) disable iff (!i_nrst)
        low_s && !stop_s |=> event_flags[BIT_SUPPLY_LOW])
        else $error("low supply flag not set");
    AST_STOP_NO_LOW: assert property (@(posedge i_clock) disable iff (!i_nrst)
        stop_s && !event_flags[BIT_SUPPLY_LOW] |=> !event_flags[BIT_SUPPLY_LOW])
        else $error("low supply flag set in stop");
    AST_HIGH_SIDE: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (low_s || high_s) && !stop_s |=> o_high_side_off)
        else $error("high sides not switched off");
    AST_IRQ_LEVEL: assert property (@(posedge i_clock) disable iff (!i_nrst)
        ##1 (o_irq_oe_n == !(|(event_flags & event_enables))))
        else $error("interrupt out of step with enabled flags");
    AST_HOT_KEEPS: assert property (@(posedge i_clock) disable iff (!i_nrst)
        hot_s && event_flags[BIT_OVERTEMP] |=> event_flags[BIT_OVERTEMP])
        else $error("over-temperature flag lost");
    AST_LINE_EDGE: assert property (@(posedge i_clock) disable iff (!i_nrst)
        line_fall |=> event_flags[BIT_LINE_EDGE])
        else $error("line edge not flagged");
    AST_RST_LINE: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (|rst_s) |=> !o_sys_rst_oe_n && !o_sys_rst_out)
        else $error("reset line not pulled");
    AST_ZERO_BITS: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (event_flags & ~REG_USED_MASK) == 8'h00 && (event_enables & ~REG_USED_MASK) == 8'h00)
        else $error("reserved bits set");
    AST_WAKE: assert property (@(posedge i_clock) disable iff (!i_nrst)
        stop_s && (wdog_s || lvr_s) |=> o_wake_host && o_wake_regulator)
        else $error("wake-up not raised");
endmodule : siw_supervisor
`default_nettype wire

//--- sim/siw_host_model.sv
// Host side model: serial register master of the supervisor die
`default_nettype none
module siw_host_model (
    input  wire logic i_clock,
    input  wire logic i_miso,
    input  wire logic i_miso_oe_n,
    output logic      o_ss_n,
    output logic      o_sck,
    output logic      o_mosi
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        o_ss_n = 1'b1;
        o_sck  = 1'b0;
        o_mosi = 1'b0;
    end

    // Phases of 6 clocks keep the synchroniser and miso latency covered
    task automatic xfer(input logic [4:0] a, input logic rw, input logic [7:0] d, output logic [15:0] rx);
        logic [15:0] tx;
        tx = {a, rw, ^{a, rw}, 1'b0, d};
        @(posedge i_clock);
        o_ss_n <= 1'b0;
        repeat (6) @(posedge i_clock);
        for (int i = 15; i >= 0; i--) begin
            o_sck  <= 1'b1;
            o_mosi <= tx[i];
            repeat (6) @(posedge i_clock);
            rx[i] = i_miso_oe_n ? ~i_miso : i_miso;
            o_sck <= 1'b0;
            repeat (6) @(posedge i_clock);
        end
        o_ss_n <= 1'b1;
        // Released data line must not keep its last value
        o_mosi <= ~o_mosi;
        repeat (10) @(posedge i_clock);
    endtask : xfer
endmodule : siw_host_model
`default_nettype wire

//--- sim/tb_siw_supervisor.sv
// Self-checking testbench for the supervisor interrupt and wake-up block
`default_nettype none
module tb_siw_supervisor
    import siw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk, nrst, line, oc_clr, stop, wdw, slr, chop;
    logic [2:0]  cond;
    logic [4:0]  oc;
    logic [3:0]  rsrc;
    logic [15:0] rx;
    wire         ss_n, sck, mosi, miso, miso_oe_n, irq_out, irq_oe_n, rst_out, rst_oe_n, hs_off, wk_h, wk_r, pwm;
    // Interrupt pin has a pull-up
    wire         irq_pin = irq_oe_n ? 1'b1 : irq_out;
    int          n_errors, total_checks;

    siw_supervisor #(.CHOP_MAX_CYCLES(64)) dut_u (
        .i_clock(clk), .i_nrst(nrst), .i_ss_n(ss_n), .i_sck(sck), .i_mosi(mosi),
        .o_miso(miso), .o_miso_oe_n(miso_oe_n), .i_supply_low(cond[0]), .i_supply_high(cond[1]),
        .i_overtemp(cond[2]), .i_line_rx(line), .i_overcurrent(oc), .i_overcurrent_clr(oc_clr),
        .i_stop_mode(stop), .i_watchdog_wake(wdw), .i_supply_low_reset(slr), .i_reset_sources(rsrc),
        .i_chop_freq_in(chop), .o_irq_out(irq_out), .o_irq_oe_n(irq_oe_n), .o_sys_rst_out(rst_out),
        .o_sys_rst_oe_n(rst_oe_n), .o_high_side_off(hs_off), .o_wake_host(wk_h),
        .o_wake_regulator(wk_r), .o_chop_pwm(pwm));

    siw_host_model host_u (.i_clock(clk), .i_miso(miso), .i_miso_oe_n(miso_oe_n),
        .o_ss_n(ss_n), .o_sck(sck), .o_mosi(mosi));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        host_u.xfer(a, 1'b0, d, rx);
    endtask : wr

    task automatic rd(input logic [4:0] a);
        host_u.xfer(a, 1'b1, 8'h00, rx);
    endtask : rd

    task automatic conclude();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    task automatic t_regs();
        rd(ADDR_ENABLES);
        chk(rx, 16'h0000);
        chk({irq_pin, rst_oe_n, rst_out, irq_out}, 16'h000c);
        wr(ADDR_ENABLES, 8'hff);
        rd(ADDR_ENABLES);
        chk(rx[7:0], REG_USED_MASK);
        rd(5'h1f);
        chk(rx[7:0], READ_UNMAPPED);
        wr(ADDR_FLAGS, 8'hff);
        wr(ADDR_ENABLES, 8'h00);
        chk(rx[7:0], REG_USED_MASK);
        chk(rx[15:8], 8'h00);
    endtask : t_regs

    task automatic t_cond();
        logic [7:0] b;
        for (int k = 0; k < 3; k++) begin
            b = 8'h01 << ((k == 0) ? BIT_SUPPLY_LOW : (k == 1) ? BIT_SUPPLY_HIGH : BIT_OVERTEMP);
            cond <= 3'h1 << k;
            tick(6);
            chk(irq_pin, 1'b1);
            chk(hs_off, k < 2);
            rd(ADDR_FLAGS);
            chk(rx[7:0], b);
            wr(ADDR_ENABLES, b);
            chk(irq_pin, 1'b0);
            wr(ADDR_FLAGS, b);
            rd(ADDR_FLAGS);
            chk(rx[7:0], b);
            cond <= 3'h0;
            tick(6);
            wr(ADDR_FLAGS, 8'hc1);
            rd(ADDR_FLAGS);
            chk(rx[7:0], b);
            wr(ADDR_FLAGS, b);
            rd(ADDR_FLAGS);
            chk({rx[7:0], irq_pin}, 9'h001);
        end
    endtask : t_cond

    task automatic t_stop();
        stop <= 1'b1;
        cond <= 3'b111;
        tick(8);
        rd(ADDR_FLAGS);
        chk({rx[7:0], hs_off}, 9'h000);
        cond <= 3'b000;
        for (int e = 0; e < 2; e++) begin
            wr(ADDR_ENABLES, e ? 8'h20 : 8'h00);
            line <= 1'b0;
            tick(6);
            chk({wk_h, wk_r}, {2{e[0]}});
            line <= 1'b1;
            stop <= 1'b0;
            tick(6);
            stop <= 1'b1;
            tick(6);
        end
        for (int j = 0; j < 2; j++) begin
            stop <= 1'b1;
            {wdw, slr} <= j ? 2'b01 : 2'b10;
            tick(6);
            chk({wk_h, wk_r}, 2'b11);
            {wdw, slr} <= 2'b00;
            stop <= 1'b0;
            tick(6);
            chk({wk_h, wk_r}, 2'b00);
        end
        stop <= 1'b0;
        wr(ADDR_FLAGS, 8'h20);
        line <= 1'b0;
        tick(6);
        chk(irq_pin, 1'b0);
        line <= 1'b1;
        wr(ADDR_FLAGS, 8'h20);
        chk(irq_pin, 1'b1);
    endtask : t_stop

    task automatic t_oc();
        wr(ADDR_ENABLES, 8'h02);
        for (int s = 0; s < 5; s++) begin
            oc <= 5'h01 << s;
            tick(6);
            oc <= 5'h00;
            wr(ADDR_FLAGS, 8'h02);
            rd(ADDR_FLAGS);
            chk({rx[7:0], irq_pin}, 9'h004);
            oc_clr <= 1'b1;
            tick(1);
            oc_clr <= 1'b0;
            tick(4);
            chk(irq_pin, 1'b1);
        end
        for (int r = 0; r < 4; r++) begin
            rsrc <= 4'h1 << r;
            tick(6);
            chk({rst_oe_n, rst_out}, 2'b00);
            rsrc <= 4'h0;
            tick(6);
            chk(rst_oe_n, 1'b1);
        end
    endtask : t_oc

    task automatic t_chop();
        int hi;
        hi = 0;
        fork
            repeat (6) begin
                chop <= 1'b1;
                tick(10);
                chop <= 1'b0;
                tick(10);
            end
            begin
                tick(60);
                repeat (40) begin
                    @(posedge clk);
                    hi += pwm;
                end
            end
        join
        chk(hi[15:0], 16'd20);
        tick(100);
        chk(pwm, 1'b0);
    endtask : t_chop

    initial begin
        {nrst, oc_clr, stop, wdw, slr, chop, cond, oc, rsrc} = '0;
        line = 1'b1;
        tick(16);
        nrst <= 1'b1;
        tick(4);
        t_regs();
        t_cond();
        t_stop();
        t_oc();
        t_chop();
        conclude();
    end

    // Roughly eight times the expected run length
    initial begin
        tick(80000);
        n_errors++;
        conclude();
    end
endmodule : tb_siw_supervisor
`default_nettype wire
